// *** lcd_seg_map.svh ***
/*
 * constants of the lcd segment loader: control byte layout, reset values,
 * bus framing and counts.
 * assumes inclusion by bare name from the design file.
 */
`ifndef LCD_SEG_MAP_SVH
`define LCD_SEG_MAP_SVH

`define CTRL_MODE_BIT      7
`define CTRL_BANK_BIT      6
`define CTRL_RESET         8'h00
`define SEG_RESET          8'h00
`define SLAVE_ADDR_DEFAULT 7'h3b
`define BITS_PER_BYTE      4'h8
`define BIT_CNT_RESET      4'h0
`define SBV_STEP_DIRECT    6'h02
`define SBV_STEP_DUPLEX    6'h01
`define SEG_REG_COUNT      8
`define SEG_GROUPS         4
`define SEG_OUT_RESET      32'h0000_0000

`endif

// *** lcd_seg_pkg.sv ***
/*
 * types of the lcd segment loader: bus states, byte phases and the
 * control byte.
 * assumes nothing beyond a systemverilog compiler.
 */
package lcd_seg_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RECV = 3'b010,
        ST_ACK  = 3'b100
    } bus_state_e;

    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_CTRL = 3'b010,
        PH_DATA = 3'b100
    } byte_phase_e;

    typedef struct packed {
        logic       mode;
        logic       bank;
        logic [5:0] segment_byte_vector;
    } ctrl_s;

endpackage

// *** lcd_segment_i2c_loader.sv ***
/*
 * i2c slave receiver and display mapper of the lcd segment driver.
 * assumes scl, sda and the subaddress pins are asynchronous to clock and
 * that the wire level of sda is resolved outside from sda_oe_n.
 *
 */
`include "lcd_seg_map.svh"

module lcd_segment_i2c_loader
    import lcd_seg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic [2:0]  hardware_subaddress_pins,
    output logic [31:0]      segment_outputs,
    output logic [31:0]      segment_outputs_bp2,
    output logic             backplane_one,
    output logic             backplane_two
);

    // chip selection from the vector and the synchronised pins
    function automatic logic chip_selected(input ctrl_s c,
                                           input logic [2:0] pins);
        if (c.mode) begin
            chip_selected = (c.segment_byte_vector[4:3] == pins[1:0]);
        end else begin
            chip_selected = (c.segment_byte_vector[5:3] == pins);
        end
    endfunction

    // synchronisers: first stage is read only by the second
    logic        scl_s1_ff;
    logic        scl_s2_ff;
    logic        scl_d3_ff;
    logic        sda_s1_ff;
    logic        sda_s2_ff;
    logic        sda_d3_ff;
    logic [2:0]  sub_s1_ff;
    logic [2:0]  sub_s2_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d3_ff <= 1'b1;
            sub_s1_ff <= 3'h0;
            sub_s2_ff <= 3'h0;
        end else begin
            scl_s1_ff <= scl;
            scl_s2_ff <= scl_s1_ff;
            scl_d3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d3_ff <= sda_s2_ff;
            sub_s1_ff <= hardware_subaddress_pins;
            sub_s2_ff <= sub_s1_ff;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_s2_ff & ~scl_d3_ff;
    assign scl_fall  = ~scl_s2_ff & scl_d3_ff;
    assign start_det = scl_s2_ff & scl_d3_ff & sda_d3_ff & ~sda_s2_ff;
    assign stop_det  = scl_s2_ff & scl_d3_ff & ~sda_d3_ff & sda_s2_ff;

    // protocol and register state
    bus_state_e  state_ff;
    bus_state_e  nxt_state;
    byte_phase_e phase_ff;
    byte_phase_e nxt_phase;
    logic [3:0]  bit_cnt_ff;
    logic [3:0]  nxt_bit_cnt;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic        ack_ff;
    logic        nxt_ack;
    ctrl_s       ctrl_ff;
    ctrl_s       nxt_ctrl;
    logic [7:0]  seg_ff     [`SEG_REG_COUNT];
    logic [7:0]  nxt_seg    [`SEG_REG_COUNT];
    logic        byte_done;

    assign byte_done = (state_ff == ST_RECV) && scl_fall
                       && (bit_cnt_ff == `BITS_PER_BYTE);

    always_comb begin
        nxt_state   = state_ff;
        nxt_phase   = phase_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift   = shift_ff;
        nxt_ack     = ack_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_seg     = seg_ff;
        if (stop_det) begin
            // loading ends, segment data left as it is
            nxt_state = ST_IDLE;
            nxt_ack   = 1'b0;
        end else if (start_det) begin
            nxt_state   = ST_RECV;
            nxt_phase   = PH_ADDR;
            nxt_bit_cnt = `BIT_CNT_RESET;
            nxt_ack     = 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    // only a start leaves idle
                    nxt_ack = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise && bit_cnt_ff != `BITS_PER_BYTE) begin
                        nxt_shift   = {shift_ff[6:0], sda_s2_ff};
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        nxt_bit_cnt = `BIT_CNT_RESET;
                        unique case (phase_ff)
                            PH_ADDR: begin
                                if (shift_ff[7:1] == SLAVE_ADDR
                                    && !shift_ff[0]) begin
                                    nxt_ack   = 1'b1;
                                    nxt_state = ST_ACK;
                                    nxt_phase = PH_CTRL;
                                end else begin
                                    nxt_state = ST_IDLE;
                                end
                            end
                            PH_CTRL: begin
                                nxt_ctrl  = shift_ff;
                                nxt_ack   = 1'b1;
                                nxt_state = ST_ACK;
                                nxt_phase = PH_DATA;
                            end
                            PH_DATA: begin
                                if (chip_selected(ctrl_ff, sub_s2_ff)) begin
                                    nxt_seg[ctrl_ff.segment_byte_vector[2:0]]
                                        = shift_ff;
                                    nxt_ack = 1'b1;
                                end else begin
                                    nxt_ack = 1'b0;
                                end
                                // every addressed chip steps its copy alike
                                // (wraps at six bits)
                                nxt_ctrl.segment_byte_vector =
                                    ctrl_ff.segment_byte_vector
                                    + (ctrl_ff.mode ? `SBV_STEP_DUPLEX
                                                    : `SBV_STEP_DIRECT);
                                nxt_state = ST_ACK;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // hold the line through the whole ninth pulse
                    if (scl_fall) begin
                        nxt_state = ST_RECV;
                        nxt_ack   = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            phase_ff   <= PH_ADDR;
            bit_cnt_ff <= `BIT_CNT_RESET;
            shift_ff   <= 8'h00;
            ack_ff     <= 1'b0;
            ctrl_ff    <= `CTRL_RESET;
            for (int i = 0; i < `SEG_REG_COUNT; i++) begin
                seg_ff[i] <= `SEG_RESET;
            end
        end else begin
            state_ff   <= nxt_state;
            phase_ff   <= nxt_phase;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff   <= nxt_shift;
            ack_ff     <= nxt_ack;
            ctrl_ff    <= nxt_ctrl;
            seg_ff     <= nxt_seg;
        end
    end

    // display mapping
    logic [31:0] nxt_seg_out;
    logic [31:0] nxt_seg_out_bp2;
    logic        nxt_bp_one;
    logic        nxt_bp_two;
    logic        nxt_sda_oe_n;

    for (genvar g = 0; g < `SEG_GROUPS; g++) begin : g_map
        assign nxt_seg_out[g*8 +: 8] =
            (ctrl_ff.mode || !ctrl_ff.bank) ? seg_ff[2*g] : seg_ff[2*g+1];
        assign nxt_seg_out_bp2[g*8 +: 8] =
            ctrl_ff.mode ? seg_ff[2*g+1] : 8'h00;
    end

    assign nxt_bp_one   = 1'b1;
    assign nxt_bp_two   = ctrl_ff.mode;
    // open drain, only ever pulled low
    assign nxt_sda_oe_n = !((nxt_state == ST_ACK) && nxt_ack);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            segment_outputs     <= `SEG_OUT_RESET;
            segment_outputs_bp2 <= `SEG_OUT_RESET;
            backplane_one       <= 1'b0;
            backplane_two       <= 1'b0;
            sda_out             <= 1'b0;
            sda_oe_n            <= 1'b1;
        end else begin
            segment_outputs     <= nxt_seg_out;
            segment_outputs_bp2 <= nxt_seg_out_bp2;
            backplane_one       <= nxt_bp_one;
            backplane_two       <= nxt_bp_two;
            sda_out             <= 1'b0;
            sda_oe_n            <= nxt_sda_oe_n;
        end
    end

    // checks
    start_recv_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        start_det && !stop_det |=> state_ff == ST_RECV
            && phase_ff == PH_ADDR && bit_cnt_ff == 4'h0)
        else $error("start not taken");

    stop_idle_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        stop_det |=> state_ff == ST_IDLE ##1 sda_oe_n)
        else $error("stop did not end loading");

    addr_nak_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        byte_done && phase_ff == PH_ADDR && !start_det && !stop_det
        && (shift_ff[7:1] != SLAVE_ADDR || shift_ff[0])
        |=> state_ff == ST_IDLE ##1 sda_oe_n)
        else $error("foreign address acknowledged");

    ctrl_store_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        byte_done && phase_ff == PH_CTRL && !start_det && !stop_det
        |=> ctrl_ff == $past(shift_ff) ##1 !sda_oe_n)
        else $error("control byte not stored or acked");

    sbv_step_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        byte_done && phase_ff == PH_DATA && !start_det && !stop_det
        |=> ctrl_ff.segment_byte_vector ==
            6'($past(ctrl_ff.segment_byte_vector)
               + ($past(ctrl_ff.mode) ? 6'h01 : 6'h02)))
        else $error("vector step wrong");

    ack_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(sda_oe_n) |-> !sda_oe_n throughout
            (state_ff == ST_ACK && ack_ff) [*2])
        else $error("ack released early");

    direct_bank_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !ctrl_ff.mode |=> segment_outputs[7:0] ==
            $past(seg_ff[{2'b00, ctrl_ff.bank}])
            && segment_outputs[31:24] ==
            $past(seg_ff[{2'b11, ctrl_ff.bank}]))
        else $error("direct bank mapping wrong");

    duplex_map_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        ctrl_ff.mode |=> segment_outputs[15:8] == $past(seg_ff[2])
            && segment_outputs_bp2[15:8] == $past(seg_ff[3]))
        else $error("duplex mapping wrong");

    bp_direct_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !ctrl_ff.mode |=> backplane_one && !backplane_two
            && segment_outputs_bp2 == 32'h0000_0000)
        else $error("second backplane used in direct mode");

    reset_clear_a: assert property (
        @(posedge clock)
        sys_rst |=> ctrl_ff == 8'h00 && state_ff == ST_IDLE
            && seg_ff[5] == 8'h00 && sda_oe_n)
        else $error("reset did not clear state");

    addr_ack_c: cover property (@(posedge clock) disable iff (sys_rst)
        byte_done && phase_ff == PH_ADDR ##1 phase_ff == PH_CTRL);
    data_write_c: cover property (@(posedge clock) disable iff (sys_rst)
        byte_done && phase_ff == PH_DATA
        && chip_selected(ctrl_ff, sub_s2_ff));
    sbv_wrap_c: cover property (@(posedge clock) disable iff (sys_rst)
        ctrl_ff.segment_byte_vector == 6'h3f
        ##1 ctrl_ff.segment_byte_vector == 6'h00);
    stop_after_ctrl_c: cover property (@(posedge clock)
        disable iff (sys_rst)
        phase_ff == PH_DATA && stop_det);

endmodule

// *** i2c_master_model.sv ***
/*
 * behavioural i2c bus master that writes to the lcd segment loader.
 * assumes the bench resolves the pulled-up sda wire from sda_pull.
 */
module i2c_master_model #(
    parameter int HALF = 4
) (
    input  wire logic clock,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus idle: both lines high, clock stands still
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask

    // also serves as a repeated start: sda released before scl rises
    task automatic start_cond;
        sda_pull <= 1'b0;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_pull <= 1'b1;
        hold(HALF);
        scl <= 1'b0;
        hold(HALF / 2);
    endtask

    task automatic stop_cond;
        sda_pull <= 1'b1;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_pull <= 1'b0;
        hold(HALF);
    endtask

    // sda moves half a low phase after scl falls, never while high;
    // the slave sees both pins three clocks late, so keep HALF >= 4
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull <= ~b[i];
            hold(HALF / 2);
            scl <= 1'b1;
            hold(HALF);
            scl <= 1'b0;
            hold(HALF / 2);
        end
        sda_pull <= 1'b0;
        hold(HALF / 2);
        scl <= 1'b1;
        hold(HALF / 2);
        ack = ~sda_wire;
        hold(HALF / 2);
        scl <= 1'b0;
        hold(HALF / 2);
    endtask
endmodule

// *** lcd_segment_i2c_loader_test.sv ***
/*
 * self-checking bench of the lcd segment loader with an i2c master model.
 * assumes a 200 ns scl period; the loader sees the pins three clocks late.
 */
module lcd_segment_i2c_loader_test
    import lcd_seg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] DEV_ADDR = 7'h2c;

    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  pins = 3'h0;
    logic        scl, sda_pull, sda_out, sda_oe_n, bp1, bp2;
    logic [31:0] out1, out2;
    wire  logic  sda_wire = ~sda_pull & (sda_oe_n | sda_out);
    logic [7:0]  seg_m [8];
    ctrl_s       ctrl_m;
    int          fails = 0;
    int          compares = 0;

    always #12.5 clock = ~clock;

    // four 25 ns clocks a half gives the 200 ns bus period
    i2c_master_model #(.HALF(4)) master_u (
        .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

    lcd_segment_i2c_loader #(.SLAVE_ADDR(DEV_ADDR)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .hardware_subaddress_pins(pins), .segment_outputs(out1),
        .segment_outputs_bp2(out2), .backplane_one(bp1),
        .backplane_two(bp2));

    task automatic chk(input string what, input logic [31:0] exp, seen);
        compares++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    task automatic check_disp;
        logic [31:0] e1, e2, e3;
        repeat (10) @(posedge clock);
        e3 = {30'h0, 1'b1, ctrl_m.mode};
        for (int g = 0; g < 4; g++) begin
            e1[8*g+:8] = ctrl_m.mode ? seg_m[2*g] : seg_m[2*g+ctrl_m.bank];
            e2[8*g+:8] = ctrl_m.mode ? seg_m[2*g+1] : 8'h00;
        end
        chk("segment_outputs", e1, out1);
        chk("segment_outputs_bp2", e2, out2);
        chk("backplanes", e3, {30'h0, bp1, bp2});
    endtask

    // head of a write: start, address and control byte
    task automatic head(input logic [7:0] ctl);
        logic a;
        master_u.start_cond();
        master_u.send_byte({DEV_ADDR, 1'b0}, a);
        chk("addr ack", 32'h1, {31'h0, a});
        master_u.send_byte(ctl, a);
        chk("ctrl ack", 32'h1, {31'h0, a});
        ctrl_m = ctl;
    endtask

    task automatic load(input logic [7:0] ctl, input int n);
        logic       a, sel;
        logic [7:0] d;
        logic [5:0] v;
        head(ctl);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            v = ctrl_m.segment_byte_vector;
            sel = ctrl_m.mode ? (v[4:3] == pins[1:0]) : (v[5:3] == pins);
            master_u.send_byte(d, a);
            chk("data ack", 32'(sel), 32'(a));
            if (sel) seg_m[v[2:0]] = d;
            v = v + (ctrl_m.mode ? 6'h01 : 6'h02);
            ctrl_m.segment_byte_vector = v;
        end
        master_u.stop_cond();
        check_disp();
    endtask

    task automatic refused(input logic [7:0] b);
        logic a;
        master_u.start_cond();
        master_u.send_byte(b, a);
        chk("refused ack", 32'h0, {31'h0, a});
        master_u.send_byte(8'hc5, a);
        chk("after refusal", 32'h0, {31'h0, a});
        master_u.stop_cond();
        check_disp();
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (seg_m[i]) seg_m[i] = 8'h00;
        ctrl_m = 8'h00;
    endtask

    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        // the whole sequence needs well under 10000 clocks
        repeat (20000) @(posedge clock);
        fails++;
        end_sim();
    end

    initial begin
        void'($urandom(48));
        do_reset();
        pins <= 3'h2;
        check_disp();
        refused({DEV_ADDR ^ 7'h01, 1'b0});
        refused({DEV_ADDR, 1'b1});
        load(8'h10, 4);
        load(8'h11, 4);  // odd bank loaded, even shown
        head(8'h40);
        master_u.stop_cond();
        check_disp();
        load(8'h58, 2);
        // repeated start in mid-transfer goes back to the address byte
        head(8'h10);
        load(8'h12, 2);
        @(posedge clock) pins <= 3'h0;
        load(8'h3e, 3);
        @(posedge clock) pins <= 3'h4;
        load(8'hbf, 3);
        for (int k = 0; k < 6; k++) begin
            logic [7:0] c;
            @(posedge clock) pins <= 3'($urandom);
            c = 8'($urandom);
            @(posedge clock);
            if ($urandom % 2) c[5:3] = pins;
            load(c, 1 + $urandom % 5);
        end
        do_reset();
        check_disp();
        end_sim();
    end
endmodule
